// File: rtl/sar_adc_conv_ctrl.sv
// Conversion control of an 8-bit successive-approximation converter.
// Assumes strobes and comparator arrive asynchronously; the ladder
// trial word leaves on TRIAL_CODE and the data pins are resolved outside.
`timescale 1ns/1ns
`default_nettype none
`include "sar_adc_defines.svh"

module sar_adc_conv_ctrl (
    input  wire logic               REF_CLK,
    input  wire logic               RST_N,
    input  wire logic               CS_N,
    input  wire logic               WR_N,
    input  wire logic               RD_N,
    input  wire logic               COMP_HIGH,
    output sar_adc_pkg::code_t      TRIAL_CODE,
    output sar_adc_pkg::code_t      DATA_OUT,
    output logic                    DATA_OE,
    output logic                    CONV_DONE_N
);
    import sar_adc_pkg::*;

    logic [3:0]  sync_out;
    logic        cs_s;
    logic        wr_s;
    logic        rd_s;
    logic        comp_s;
    logic [1:0]  phase;
    logic        tick;
    conv_state_t state;
    conv_state_t next_state;
    logic        shift_entry_flop;
    code_t       shift_reg;
    code_t       approx_register;
    code_t       kept_code;
    logic        half;
    logic        set_cond;
    logic        rd_sel;
    logic        start_clear_gate;
    logic        trial_end;
    logic        result_transfer_gate;
    logic        done_pend;
    logic [3:0]  set_cnt;
    logic [6:0]  conv_cnt;

    input_sync #(
        .WIDTH   (4),
        .RST_VAL (`SYNC_IDLE)
    ) u_sync (
        .clk   (REF_CLK),
        .rst_n (RST_N),
        .din   ({CS_N, WR_N, RD_N, COMP_HIGH}),
        .dout  (sync_out)
    );

    assign cs_s   = sync_out[3];
    assign wr_s   = sync_out[2];
    assign rd_s   = sync_out[1];
    assign comp_s = sync_out[0];

    // Strobes are active low
    assign set_cond = !cs_s && !wr_s; // R4 R18
    assign rd_sel   = !cs_s && !rd_s; // R18

    // Internal phases run at a quarter of the converter clock
    assign tick = (phase == `PHASE_LAST);

    // Release only once the set condition has gone
    assign start_clear_gate = tick && (state == ST_RESET)
                              && shift_entry_flop && !set_cond; // R9

    assign trial_end = tick && half && (state == ST_CONVERT);

    // Comparator low means the trial bit overshot, so it is dropped
    assign kept_code = comp_s ? approx_register
                              : (approx_register & ~shift_reg); // R17

    assign result_transfer_gate = trial_end && shift_reg[0]; // R10

    assign TRIAL_CODE = approx_register;

    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:    if (set_cond) next_state = ST_RESET; // R8
            ST_RESET:   if (start_clear_gate) next_state = ST_CONVERT; // R7
            ST_CONVERT:
            begin
                if (set_cond)
                    next_state = ST_RESET; // R3
                else if (result_transfer_gate)
                    next_state = ST_IDLE;
            end
            default:    next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            phase <= 2'h0;
            state <= ST_IDLE;
        end
        else
        begin
            phase <= phase + 2'h1;
            state <= next_state;
        end
    end

    // Entry stage takes the one while the start flop holds
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N || state != ST_RESET || start_clear_gate)
            shift_entry_flop <= 1'b0;
        else if (tick)
            shift_entry_flop <= 1'b1; // R8
    end

    // Marker and trial word; held clear while start is active
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N || set_cond || (state == ST_RESET && !start_clear_gate))
        begin
            shift_reg       <= `CODE_ZERO; // R6
            approx_register <= `CODE_ZERO; // R6
            half            <= 1'b0;
        end
        else if (start_clear_gate)
        begin
            shift_reg       <= `CODE_MSB_MARK; // R1
            approx_register <= `CODE_MSB_MARK; // R1
            half            <= 1'b0;
        end
        else if (state == ST_CONVERT && tick)
        begin
            half <= !half;
            if (half)
            begin
                shift_reg       <= shift_reg >> 1;
                approx_register <= kept_code | (shift_reg >> 1); // R1
            end
        end
    end

    // Result word moves out one clock ahead of the done edge
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            DATA_OUT  <= `CODE_ZERO;
            done_pend <= 1'b0;
        end
        else
        begin
            if (result_transfer_gate)
                DATA_OUT <= kept_code; // R2
            done_pend <= result_transfer_gate && !set_cond; // R16
        end
    end

    // Set interval stretches the done edge over eight clocks
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N || set_cond || state == ST_RESET)
            set_cnt <= 4'h0;
        else if (done_pend)
            set_cnt <= `SET_PERIODS; // R11
        else if (set_cnt != 4'h0)
            set_cnt <= set_cnt - 4'h1;
    end

    // A restart wins over everything; set beats read while active
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
            CONV_DONE_N <= 1'b1;
        else if (set_cond || state == ST_RESET)
            CONV_DONE_N <= 1'b1; // R13
        else if (done_pend)
            CONV_DONE_N <= 1'b0; // R2
        else if (rd_sel && set_cnt <= `SET_LAST)
            CONV_DONE_N <= 1'b1; // R12 R14
    end

    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
            DATA_OE <= 1'b0;
        else
            DATA_OE <= rd_sel; // R19
    end

    // Cycle count from launch, used only by the checks below
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N || start_clear_gate)
            conv_cnt <= 7'h0;
        else if (conv_cnt != `CONV_CLOCKS)
            conv_cnt <= conv_cnt + 7'h1;
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    chk_conv_length: assert property ( // R1
        result_transfer_gate |-> conv_cnt == `CONV_LAST_CNT)
        else $error("conversion did not take 64 clocks");

    chk_msb_first: assert property ( // R1
        start_clear_gate |=> approx_register == 8'h80 && shift_reg == 8'h80)
        else $error("first trial is not the msb");

    chk_latch_first: assert property ( // R16
        $fell(CONV_DONE_N) |-> $past(result_transfer_gate, 2)
                              && $changed(DATA_OUT) == 1'b0)
        else $error("done fell without a prior result transfer");

    chk_done_follows: assert property ( // R2
        done_pend && !set_cond && state != ST_RESET |=> !CONV_DONE_N)
        else $error("done not asserted after transfer");

    chk_set_width: assert property ( // R11
        $fell(CONV_DONE_N) |-> set_cnt == 4'h8)
        else $error("set interval not loaded with eight");

    chk_read_blocked: assert property ( // R12
        !CONV_DONE_N && set_cnt > 4'h1 && !set_cond && state != ST_RESET
        |=> !CONV_DONE_N)
        else $error("done released inside the set interval");

    chk_read_clears: assert property ( // R14
        !CONV_DONE_N && rd_sel && set_cnt <= 4'h1 && !done_pend
        |=> CONV_DONE_N)
        else $error("read did not clear done");

    chk_output_enable: assert property ( // R19
        1'b1 |=> DATA_OE == $past(rd_sel))
        else $error("output enable does not follow select and read");

    chk_start_abort: assert property ( // R3
        set_cond |=> state == ST_RESET && shift_reg == 8'h00
                     && approx_register == 8'h00 && CONV_DONE_N)
        else $error("start did not reset the converter");

    chk_hold_reset: assert property ( // R9
        set_cond && state == ST_RESET |=> state == ST_RESET)
        else $error("start flop released under a held strobe");

    chk_bit_drop: assert property ( // R17
        trial_end && !comp_s |=> (approx_register & $past(shift_reg)) == 8'h00)
        else $error("overshooting trial bit was kept");

    cov_full_conversion: cover property (result_transfer_gate);
    cov_free_running: cover property ( // R4
        $fell(CONV_DONE_N) ##[1:8] set_cond);
    cov_abort: cover property (set_cond && state == ST_CONVERT);
    cov_read_during_set: cover property (rd_sel && set_cnt > 4'h1);

endmodule : sar_adc_conv_ctrl

`default_nettype wire

// File: inc/sar_adc_defines.svh
// Constants of the successive-approximation conversion control block.
// Assumes one converter clock, REF_CLK at 100 MHz, and active-low strobes.
//
// Overview of operation
// R1: MSB first, eight trials in 64 clocks
// R2: Latch straight binary result, then assert done
// R3: New start aborts a running conversion
// R4: Done fed to start gives free-running mode
// R5: Host gives one start pulse at power-up
// R6: Start edge clears approximation and shift register
// R7: Conversion begins 1 to 8 clocks after release
// R8: Select and start low set start flop
// R9: Start flop clears only after set condition
// R10: Marker leaving shift register copies result out
// R11: Done set input held eight clock periods
// R12: Continuous read still gives eight-period done pulse
// R13: Free-running restart shortens the done pulse
// R14: Select and read low clear done, enable data
// R15: Host reads at least eight clocks after done
// R16: Result latch updates one clock before done
// R17: Negative input at or above positive gives zero
// R18: Select, start and read are active low
// R19: Data outputs released unless select and read low
`ifndef SAR_ADC_DEFINES_SVH
`define SAR_ADC_DEFINES_SVH

`define CODE_ZERO      8'h00
`define CODE_MSB_MARK  8'h80
`define PHASE_LAST     2'h3
`define SET_PERIODS    4'h8
`define SET_LAST       4'h1
`define CONV_CLOCKS    7'h40
`define CONV_LAST_CNT  7'h3F
`define SYNC_IDLE      4'hE

`endif

// File: inc/sar_adc_pkg.sv
// Types shared by the conversion control block.
// Assumes the defines header carries all numeric constants.
package sar_adc_pkg;

    typedef logic [7:0] code_t;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_RESET   = 2'b01,
        ST_CONVERT = 2'b10
    } conv_state_t;

endpackage : sar_adc_pkg

// File: rtl/input_sync.sv
// Three-stage synchroniser for asynchronous pins.
// Assumes one clock; output changes once stages two and three agree.
`timescale 1ns/1ns
`default_nettype none

module input_sync #(
    parameter int         WIDTH   = 4,
    parameter logic [3:0] RST_VAL = 4'h0
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] agree;

    // Stage one feeds only stage two, to keep metastability contained
    assign agree = ~(stage2 ^ stage3);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            stage1 <= RST_VAL[WIDTH-1:0];
            stage2 <= RST_VAL[WIDTH-1:0];
            stage3 <= RST_VAL[WIDTH-1:0];
            dout   <= RST_VAL[WIDTH-1:0];
        end
        else
        begin
            stage1 <= din;
            stage2 <= stage1;
            stage3 <= stage2;
            dout   <= (agree & stage3) | (~agree & dout);
        end
    end

endmodule : input_sync

`default_nettype wire

// File: dv/analog_front_model.sv
// Comparator in front of the ladder: compares a held input level with
// the trial word. Assumes the level is steady during a conversion.
`timescale 1ns/1ns
`default_nettype none

module analog_front_model (
    input  wire logic               [7:0] level,
    input  wire sar_adc_pkg::code_t       trial,
    output logic                          comp_high
);
    import sar_adc_pkg::*;

    // Zero level never reaches a tap, so the code resolves to zero
    assign comp_high = (level >= trial);
endmodule : analog_front_model

`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the conversion control block.
// Assumes the comparator model above; strobes are driven at rising edges.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    import sar_adc_pkg::*;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cs_n = 1'b1;
    logic        wr_drv = 1'b1;
    logic        rd_n = 1'b1;
    logic        free_run = 1'b0;
    logic [7:0]  level = 8'h00;
    wire         comp_high;
    wire         wr_n;
    wire         data_oe;
    wire         done_n;
    code_t       trial;
    code_t       data_out;
    int          err_total = 0;
    int          checks = 0;

    always #5 clk = ~clk;

    // Done fed back to start gives the self-restarting loop
    assign wr_n = free_run ? done_n : wr_drv;

    analog_front_model afe (.level(level), .trial(trial),
                            .comp_high(comp_high));

    sar_adc_conv_ctrl uut (.REF_CLK(clk), .RST_N(rst_n), .CS_N(cs_n),
        .WR_N(wr_n), .RD_N(rd_n), .COMP_HIGH(comp_high),
        .TRIAL_CODE(trial), .DATA_OUT(data_out), .DATA_OE(data_oe),
        .CONV_DONE_N(done_n));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic start_pulse(input int w);
        @(posedge clk);
        cs_n   <= 1'b0;
        wr_drv <= 1'b0;
        repeat (w) @(posedge clk);
        cs_n   <= 1'b1;
        wr_drv <= 1'b1;
    endtask : start_pulse

    // Counts settled cycles until done falls; bounded against a hang
    task automatic wait_done(output int n);
        n = 0;
        while (done_n !== 1'b0 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
    endtask : wait_done

    task automatic read_out(input logic [7:0] exp);
        repeat (8) @(posedge clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        repeat (8) @(negedge clk);
        chk({7'h00, data_oe}, 8'h01);
        chk({7'h00, done_n}, 8'h01);
        chk(data_out, exp);
        @(posedge clk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        repeat (8) @(negedge clk);
        chk({7'h00, data_oe}, 8'h00);
    endtask : read_out

    task automatic conv_read(input logic [7:0] v);
        int n;
        @(posedge clk);
        level <= v;
        start_pulse(4);
        wait_done(n);
        chk({7'h00, (n >= 66 && n <= 80)}, 8'h01);
        chk(data_out, v);
        repeat (7)
        begin
            @(negedge clk);
            chk({7'h00, done_n}, 8'h00);
        end
        read_out(v);
    endtask : conv_read

    // Wide third start aborts the second and holds the block in reset
    task automatic abort_wide;
        int n;
        @(posedge clk);
        level <= 8'h33;
        start_pulse(4);
        wait_done(n);
        chk(data_out, 8'h33);
        // Done is left low and unread, so the next start must clear it
        start_pulse(4);
        repeat (30) @(posedge clk);
        level  <= 8'hC3;
        cs_n   <= 1'b0;
        wr_drv <= 1'b0;
        repeat (40) @(negedge clk);
        chk(trial, 8'h00);
        chk({7'h00, done_n}, 8'h01);
        @(posedge clk);
        cs_n   <= 1'b1;
        wr_drv <= 1'b1;
        wait_done(n);
        chk(data_out, 8'hC3);
        read_out(8'hC3);
    endtask : abort_wide

    // Read held low throughout still shows a full-width done pulse
    task automatic held_read;
        int n;
        @(posedge clk);
        level <= 8'h81;
        rd_n  <= 1'b0;
        start_pulse(4);
        @(posedge clk);
        cs_n <= 1'b0;
        wait_done(n);
        chk(n < 200 ? 8'h01 : 8'h00, 8'h01);
        repeat (7)
        begin
            @(negedge clk);
            chk({7'h00, done_n}, 8'h00);
        end
        repeat (9) @(negedge clk);
        chk({7'h00, done_n}, 8'h01);
        @(posedge clk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
    endtask : held_read

    task automatic free_loop;
        int falls;
        int width;
        int widest;
        falls  = 0;
        width  = 0;
        widest = 0;
        level <= 8'h6E;
        start_pulse(4);
        @(posedge clk);
        cs_n     <= 1'b0;
        free_run <= 1'b1;
        repeat (400)
        begin
            @(negedge clk);
            if (done_n === 1'b0)
            begin
                if (width == 0)
                    falls++;
                width++;
                widest = (width > widest) ? width : widest;
            end
            else
                width = 0;
        end
        chk({7'h00, falls >= 4}, 8'h01);
        chk({7'h00, widest < 8}, 8'h01);
        chk(data_out, 8'h6E);
        @(posedge clk);
        free_run <= 1'b0;
        cs_n     <= 1'b1;
    endtask : free_loop

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    // Whole run needs about 1200 clocks; ten thousand means a hang
    initial
    begin
        #100000;
        err_total++;
        print_verdict();
    end

    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk({6'h00, done_n, data_oe}, 8'h02);
        chk(trial, 8'h00);
        conv_read(8'h00);
        conv_read(8'hFF);
        conv_read(8'hA5);
        conv_read(8'h5A);
        abort_wide();
        held_read();
        free_loop();
        print_verdict();
    end
endmodule : tb_top

`default_nettype wire
